/* logic/spapf_filters.sv */
// Second audio port record and playback filter control with Wishbone slave
module spapf_filters #(
    parameter int FS_HZ = 48000,
    parameter int HOLD_N0 = spapf_pkg::GATE_HOLD0_MS * FS_HZ / 1000,
    parameter int HOLD_N1 = spapf_pkg::GATE_HOLD1_MS * FS_HZ / 1000,
    parameter int HOLD_N2 = spapf_pkg::GATE_HOLD2_MS * FS_HZ / 1000,
    parameter int HOLD_N3 = spapf_pkg::GATE_HOLD3_MS * FS_HZ / 1000
) (
    input  wire logic                     CLOCK_I,      // System clock
    input  wire logic                     RST_N_I,      // Async reset, low
    input  wire logic [spapf_pkg::AW-1:0] WB_ADR_I,     // Byte address
    input  wire logic [31:0]              WB_DAT_I,     // Write data
    output logic      [31:0]              WB_DAT_O,     // Read data
    input  wire logic [3:0]               WB_SEL_I,     // Byte lanes
    input  wire logic                     WB_WE_I,      // Write
    input  wire logic                     WB_STB_I,     // Strobe
    input  wire logic                     WB_CYC_I,     // Cycle
    output logic                          WB_ACK_O,     // Acknowledge
    input  wire logic                     FS_STROBE_I,  // One pulse per sample
    input  wire spapf_pkg::spapf_stereo_t PB_I,         // Playback in
    input  wire spapf_pkg::spapf_stereo_t REC_I,        // Record in
    output spapf_pkg::spapf_stereo_t      PB_O,         // Playback out
    output spapf_pkg::spapf_stereo_t      REC_O,        // Record out
    output logic                          OUT_VALID_O,  // Outputs updated
    output spapf_pkg::spapf_drc_ctl_t     DRC_CTL_O,    // Range controller enables
    output logic                          SIG_DETECT_O  // Signal present
);
    import spapf_pkg::*;

    localparam int GW = 20;
    localparam logic signed [DW+1:0] SAT_MAX = (DW+2)'(2**(DW-1) - 1);
    localparam logic signed [DW+1:0] SAT_MIN = -(DW+2)'(2**(DW-1));

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel, input logic [15:0] m);
        logic [15:0] v;
        v = old;
        if (sel[0]) v[7:0] = d[7:0];
        if (sel[1]) v[15:8] = d[15:8];
        return v & m;
    endfunction : merge

    function automatic logic [DW-1:0] mag(input logic signed [DW-1:0] s);
        return s[DW-1] ? DW'(-s) : DW'(s);
    endfunction : mag

    function automatic logic signed [DW-1:0] sat(input logic signed [DW+1:0] v);
        if (v > SAT_MAX) return SAT_MAX[DW-1:0];
        if (v < SAT_MIN) return SAT_MIN[DW-1:0];
        return v[DW-1:0];
    endfunction : sat

    // Sixteen 0.375dB codes make 6dB, taken as one exact halving; 00 is silence
    localparam logic [8:0] VOL_MANT [16] = '{9'h100, 9'h0F5, 9'h0EB, 9'h0E1, 9'h0D7, 9'h0CE, 9'h0C5, 9'h0BD,
                                             9'h0B5, 9'h0AD, 9'h0A6, 9'h09F, 9'h098, 9'h092, 9'h08C, 9'h086};

    function automatic logic signed [DW-1:0] gain(input logic signed [DW-1:0] s, input logic [7:0] g);
        logic [7:0]           att;
        logic signed [DW+9:0] p;
        att = VOL_UNITY - g;
        p = (DW+10)'(s) * $signed({1'b0, VOL_MANT[att[3:0]]});
        if (g == 8'h00) return '0;
        if (g >= VOL_UNITY) return s;
        return DW'(p >>> (8 + int'(att[7:4])));
    endfunction : gain

    // Shift for one-pole DC blocker, fc ~ fs/(2*pi*2^k)
    function automatic int hpf_k(input logic [1:0] c);
        case (c)
            2'b00:   return 11;
            2'b01:   return 3;
            2'b10:   return 3;
            default: return 2;
        endcase
    endfunction : hpf_k

    function automatic logic signed [DW-1:0] hpf(input logic signed [DW-1:0] x, input logic signed [DW-1:0] x1,
                                                 input logic signed [DW-1:0] y1, input logic [1:0] c);
        logic signed [DW+1:0] a;
        a = (DW+2)'(x) - (DW+2)'(x1) + (DW+2)'(y1) - (DW+2)'(y1 >>> hpf_k(c));
        return sat(a);
    endfunction : hpf

    // Bus slave
    logic              ack;
    logic              next_ack;
    logic [31:0]       rdat;
    logic [31:0]       next_rdat;
    spapf_cfg_t        cfg;
    spapf_cfg_t        next_cfg;
    logic [7:0]        pend_l;
    logic [7:0]        pend_r;
    logic [7:0]        next_pend_l;
    logic [7:0]        next_pend_r;
    logic              vu_wr;
    logic [11:0]       idx;
    logic              req;
    logic [15:0]       stat;
    // Sample path state
    spapf_cfg_t        sh;
    spapf_cfg_t        next_sh;
    logic [7:0]        gain_l;
    logic [7:0]        gain_r;
    logic [7:0]        next_gain_l;
    logic [7:0]        next_gain_r;
    logic [4:0]        rcnt;
    logic [4:0]        next_rcnt;
    logic [GW-1:0]     qcnt;
    logic [GW-1:0]     next_qcnt;
    logic              gated;
    logic              next_gated;
    spapf_stereo_t     x1;
    spapf_stereo_t     y1;
    spapf_stereo_t     next_x1;
    spapf_stereo_t     next_y1;
    logic [DW-1:0]     env;
    logic [DW-1:0]     pk;
    logic [DW-1:0]     next_env;
    logic [DW-1:0]     next_pk;
    logic              det;
    logic              next_det;
    spapf_stereo_t     pb;
    spapf_stereo_t     rec;
    spapf_stereo_t     next_pb;
    spapf_stereo_t     next_rec;
    spapf_stereo_t     mix;
    logic              valid;

    assign idx = WB_ADR_I[AW-1:2];
    assign req = WB_CYC_I && WB_STB_I && !ack;
    assign stat = {gain_l, 5'h00, gain_l == 8'h00, gated, det};

    always_comb begin
        next_cfg = cfg;
        next_pend_l = pend_l;
        next_pend_r = pend_r;
        next_rdat = 32'h0000_0000;
        vu_wr = 1'b0;
        next_ack = req;
        // Write lands at the acknowledge edge, while the master still holds it
        if (WB_CYC_I && WB_STB_I && ack && WB_WE_I) begin
            case (idx)
                IDX_REC:  next_cfg.rec = merge(cfg.rec, WB_DAT_I, WB_SEL_I, REC_WMASK);
                IDX_PB1:  next_cfg.pb1 = merge(cfg.pb1, WB_DAT_I, WB_SEL_I, PB1_WMASK);
                IDX_PB2:  next_cfg.pb2 = merge(cfg.pb2, WB_DAT_I, WB_SEL_I, PB2_WMASK);
                IDX_GATE: next_cfg.gate = merge(cfg.gate, WB_DAT_I, WB_SEL_I, GATE_WMASK);
                IDX_DRC:  next_cfg.dynamic_range_controller = merge(cfg.dynamic_range_controller, WB_DAT_I, WB_SEL_I, DRC_WMASK);
                IDX_PB_VOL_L: begin
                    next_pend_l = 8'(merge({8'h00, pend_l}, WB_DAT_I, WB_SEL_I, VOL_WMASK));
                    vu_wr = WB_SEL_I[1] && WB_DAT_I[VU_BIT];
                end
                IDX_PB_VOL_R: begin
                    next_pend_r = 8'(merge({8'h00, pend_r}, WB_DAT_I, WB_SEL_I, VOL_WMASK));
                    vu_wr = WB_SEL_I[1] && WB_DAT_I[VU_BIT];
                end
                default: ;
            endcase
        end
        if (vu_wr) begin
            next_cfg.vol_l = next_pend_l;
            next_cfg.vol_r = next_pend_r;
        end
        if (req && !WB_WE_I) begin
            case (idx)
                IDX_REC:      next_rdat = {16'h0000, cfg.rec};
                IDX_PB1:      next_rdat = {16'h0000, cfg.pb1};
                IDX_PB2:      next_rdat = {16'h0000, cfg.pb2};
                IDX_GATE:     next_rdat = {16'h0000, cfg.gate};
                IDX_DRC:      next_rdat = {16'h0000, cfg.dynamic_range_controller};
                IDX_PB_VOL_L: next_rdat = {24'h00_0000, pend_l};
                IDX_PB_VOL_R: next_rdat = {24'h00_0000, pend_r};
                IDX_STAT:     next_rdat = {16'h0000, stat};
                default:      next_rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack <= 1'b0;
            rdat <= 32'h0000_0000;
            cfg <= CFG_RESET;
            pend_l <= VOL_RESET;
            pend_r <= VOL_RESET;
        end else begin
            ack <= next_ack;
            rdat <= next_rdat;
            cfg <= next_cfg;
            pend_l <= next_pend_l;
            pend_r <= next_pend_r;
        end
    end

    assign WB_ACK_O = ack;
    assign WB_DAT_O = rdat;

    // Sample path; settings sampled once per sample
    logic [7:0]        tgt_l;
    logic [7:0]        tgt_r;
    logic              step;
    logic [4:0]        div;
    spapf_stereo_t     wide;
    spapf_stereo_t     lev;
    logic signed [DW+6:0] dlt;
    logic [DW-1:0]     thr;
    logic [DW-1:0]     a;
    logic [DW-1:0]     rthr;
    logic [DW+8:0]     rprod;
    logic [7:0]        mant;
    logic [GW-1:0]     hold_n;

    always_comb begin
        next_sh = FS_STROBE_I ? cfg : sh;
        next_gain_l = gain_l;
        next_gain_r = gain_r;
        next_rcnt = rcnt;
        next_qcnt = qcnt;
        next_gated = gated;
        next_x1 = x1;
        next_y1 = y1;
        next_env = env;
        next_pk = pk;
        next_det = det;
        next_pb = pb;
        next_rec = rec;
        // Mono mix, halved so the sum cannot clip
        mix = next_sh.pb1.mono ? '{l: sat(((DW+2)'(PB_I.l) + (DW+2)'(PB_I.r)) >>> 1),
                                   r: sat(((DW+2)'(PB_I.l) + (DW+2)'(PB_I.r)) >>> 1)} : PB_I;
        wide = mix;
        dlt = (DW+7)'(mix.l - mix.r) * $signed({1'b0, next_sh.pb2.depth});
        if (next_sh.pb2.en && next_sh.pb2.depth != 5'h00) begin
            wide.l = sat((DW+2)'(mix.l) + (DW+2)'(dlt >>> 5));
            wide.r = sat((DW+2)'(mix.r) - (DW+2)'(dlt >>> 5));
        end
        tgt_l = next_sh.pb1.mute ? 8'h00 : next_sh.vol_l;
        tgt_r = next_sh.pb1.mute ? 8'h00 : next_sh.vol_r;
        div = next_sh.pb1.ramp_rate ? MUTE_SLOW_DIV : MUTE_FAST_DIV;
        step = (rcnt == div - 5'h01);
        lev = '{l: gain(wide.l, gain_l), r: gain(wide.r, gain_r)};
        thr = DW'(1) << (DW - 11 - int'(next_sh.gate.thr));
        case (next_sh.gate.hold)
            2'b00:   hold_n = GW'(HOLD_N0);
            2'b01:   hold_n = GW'(HOLD_N1);
            2'b10:   hold_n = GW'(HOLD_N2);
            default: hold_n = GW'(HOLD_N3);
        endcase
        a = next_sh.dynamic_range_controller.pb_en ? (mag(lev.l) > mag(lev.r) ? mag(lev.l) : mag(lev.r))
            : (next_sh.dynamic_range_controller.rec_l_en && mag(REC_I.l) > mag(REC_I.r)) || !next_sh.dynamic_range_controller.rec_r_en
            ? (next_sh.dynamic_range_controller.rec_l_en ? mag(REC_I.l) : '0) : mag(REC_I.r);
        case (next_sh.dynamic_range_controller.rms_thr[1:0])
            2'b00:   mant = 8'hFF;
            2'b01:   mant = 8'hD7;
            2'b10:   mant = 8'hB5;
            default: mant = 8'h99;
        endcase
        rprod = (DW+9)'(DW'(1) << (DW - 6)) * (DW+9)'(mant);
        rthr = DW'(rprod >> (8 + int'(next_sh.dynamic_range_controller.rms_thr[4:2])));
        if (FS_STROBE_I) begin
            next_rcnt = step ? 5'h00 : rcnt + 5'h01;
            if (gain_l > tgt_l) next_gain_l = step ? gain_l - 8'h01 : gain_l;
            if (gain_r > tgt_r) next_gain_r = step ? gain_r - 8'h01 : gain_r;
            if (gain_l < tgt_l) next_gain_l = !next_sh.pb1.unmute_ramp ? tgt_l : step ? gain_l + 8'h01 : gain_l;
            if (gain_r < tgt_r) next_gain_r = !next_sh.pb1.unmute_ramp ? tgt_r : step ? gain_r + 8'h01 : gain_r;
            if (!next_sh.gate.en || mag(lev.l) >= thr || mag(lev.r) >= thr) begin
                next_qcnt = '0;
                next_gated = 1'b0;
            end else if (qcnt >= hold_n) begin
                next_gated = 1'b1;
            end else begin
                next_qcnt = qcnt + GW'(1);
            end
            next_pb = next_gated ? '0 : lev;
            next_rec.l = next_sh.rec.left_en ? hpf(REC_I.l, x1.l, y1.l, next_sh.rec.cutoff) : REC_I.l;
            next_rec.r = next_sh.rec.right_en ? hpf(REC_I.r, x1.r, y1.r, next_sh.rec.cutoff) : REC_I.r;
            next_x1 = REC_I;
            next_y1.l = next_sh.rec.left_en ? next_rec.l : '0;
            next_y1.r = next_sh.rec.right_en ? next_rec.r : '0;
            next_env = DW'(env + ((a >> ENV_SHIFT) - (env >> ENV_SHIFT)));
            next_pk = a > pk - (pk >> ENV_SHIFT) ? a : pk - (pk >> ENV_SHIFT);
            next_det = next_sh.dynamic_range_controller.det_en && (next_sh.dynamic_range_controller.pb_en || next_sh.dynamic_range_controller.rec_l_en || next_sh.dynamic_range_controller.rec_r_en) &&
                       (next_sh.dynamic_range_controller.method ? next_env > rthr
                        : (DW+8)'(next_pk) > ((DW+8)'(next_env) << (CREST_BASE + int'(next_sh.dynamic_range_controller.crest_thr))));
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sh <= CFG_RESET;
            gain_l <= 8'h00;
            gain_r <= 8'h00;
            rcnt <= 5'h00;
            qcnt <= '0;
            gated <= 1'b0;
            x1 <= '0;
            y1 <= '0;
            env <= '0;
            pk <= '0;
            det <= 1'b0;
            pb <= '0;
            rec <= '0;
            valid <= 1'b0;
        end else begin
            sh <= next_sh;
            gain_l <= next_gain_l;
            gain_r <= next_gain_r;
            rcnt <= next_rcnt;
            qcnt <= next_qcnt;
            gated <= next_gated;
            x1 <= next_x1;
            y1 <= next_y1;
            env <= next_env;
            pk <= next_pk;
            det <= next_det;
            pb <= next_pb;
            rec <= next_rec;
            valid <= FS_STROBE_I;
        end
    end

    assign PB_O = pb;
    assign REC_O = rec;
    assign OUT_VALID_O = valid;
    assign SIG_DETECT_O = det;
    assign DRC_CTL_O = '{gate_en: sh.dynamic_range_controller.gate_en, knee2_en: sh.dynamic_range_controller.knee2_en, qr_en: sh.dynamic_range_controller.qr_en,
                         clip_en: sh.dynamic_range_controller.clip_en, pb_en: sh.dynamic_range_controller.pb_en, rec_l_en: sh.dynamic_range_controller.rec_l_en,
                         rec_r_en: sh.dynamic_range_controller.rec_r_en};

    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    a_ack_single:   assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");
    a_ack_answers:  assert property (req |=> WB_ACK_O) else $error("request not answered");
    a_shadow_hold:  assert property (!FS_STROBE_I |=> $stable(sh)) else $error("settings moved mid sample");
    a_vu_together:  assert property (vu_wr |=> cfg.vol_l == pend_l && cfg.vol_r == pend_r)
                        else $error("volumes not applied together");
    a_mute_no_rise: assert property (FS_STROBE_I && next_sh.pb1.mute |=> gain_l <= $past(gain_l))
                        else $error("gain rose while muted");
    a_mute_gradual: assert property (FS_STROBE_I && gain_l > 8'h01 |=> gain_l >= $past(gain_l) - 8'h01)
                        else $error("gain fell more than one step");
    a_unmute_jump:  assert property (FS_STROBE_I && !next_sh.pb1.mute && !next_sh.pb1.unmute_ramp
                        && gain_l <= next_sh.vol_l |=> gain_l == $past(next_sh.vol_l))
                        else $error("unmute did not jump");
    a_hpf_bypass:   assert property (FS_STROBE_I && !next_sh.rec.left_en |=> REC_O.l == $past(REC_I.l))
                        else $error("record filter not bypassed");
    a_mono_equal:   assert property (FS_STROBE_I && next_sh.pb1.mono && !next_sh.pb2.en && gain_l == gain_r
                        |=> PB_O.l == PB_O.r) else $error("mono output differs");
    a_gate_silent:  assert property (gated |-> PB_O == '0 && sh.gate.en) else $error("gate leaked");
    a_detect_off:   assert property (FS_STROBE_I && !next_sh.dynamic_range_controller.det_en |=> !SIG_DETECT_O)
                        else $error("detect while disabled");
    c_write:   cover property (req && WB_WE_I);
    c_gated:   cover property (!gated ##1 gated);
    c_detect:  cover property (!det ##1 det);
    c_muted:   cover property (gain_l == 8'h01 ##1 gain_l == 8'h00);
endmodule : spapf_filters

/* logic/spapf_pkg.sv */
// Shared constants and types for the second audio port path filter block
package spapf_pkg;
    localparam int DW = 24;
    localparam int AW = 14;
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_PB_VOL_L = 12'h502;
    localparam logic [11:0] IDX_PB_VOL_R = 12'h503;
    localparam logic [11:0] IDX_REC      = 12'h510;
    localparam logic [11:0] IDX_PB1      = 12'h520;
    localparam logic [11:0] IDX_PB2      = 12'h521;
    localparam logic [11:0] IDX_GATE     = 12'h530;
    localparam logic [11:0] IDX_DRC      = 12'h540;
    localparam logic [11:0] IDX_STAT     = 12'h550;
    localparam logic [15:0] REC_WMASK  = 16'h7800;
    localparam logic [15:0] PB1_WMASK  = 16'h02B0;
    localparam logic [15:0] PB2_WMASK  = 16'h3F00;
    localparam logic [15:0] GATE_WMASK = 16'h006F;
    localparam logic [15:0] DRC_WMASK  = 16'hFFFF;
    localparam logic [15:0] VOL_WMASK  = 16'h00FF;
    localparam int          VU_BIT     = 8;
    localparam logic [7:0]  VOL_UNITY  = 8'hC0;
    localparam logic [7:0]  VOL_RESET  = 8'hC0;
    localparam logic [4:0]  MUTE_FAST_DIV = 5'h02;
    localparam logic [4:0]  MUTE_SLOW_DIV = 5'h20;
    localparam int GATE_HOLD0_MS = 30;
    localparam int GATE_HOLD1_MS = 125;
    localparam int GATE_HOLD2_MS = 250;
    localparam int GATE_HOLD3_MS = 500;
    localparam int ENV_SHIFT     = 6;
    localparam int CREST_BASE    = 2;
    typedef struct packed {logic rsv15; logic [1:0] cutoff; logic left_en; logic right_en; logic [10:0] rsv;} spapf_rec_t;
    typedef struct packed {logic [5:0] rsv10; logic mute; logic rsv8; logic mono; logic rsv6;
                           logic ramp_rate; logic unmute_ramp; logic [3:0] rsv;} spapf_pb1_t;
    typedef struct packed {logic [1:0] rsv14; logic [4:0] depth; logic en; logic [7:0] rsv;} spapf_pb2_t;
    typedef struct packed {logic [8:0] rsv7; logic [1:0] hold; logic rsv4; logic [2:0] thr; logic en;} spapf_gate_t;
    typedef struct packed {logic [4:0] rms_thr; logic [1:0] crest_thr; logic gate_en; logic method; logic det_en;
                           logic knee2_en; logic qr_en; logic clip_en; logic pb_en; logic rec_l_en;
                           logic rec_r_en;} spapf_drc_t;
    typedef struct packed {spapf_rec_t rec; spapf_pb1_t pb1; spapf_pb2_t pb2; spapf_gate_t gate; spapf_drc_t dynamic_range_controller;
                           logic [7:0] vol_l; logic [7:0] vol_r;} spapf_cfg_t;
    typedef struct packed {logic signed [DW-1:0] l; logic signed [DW-1:0] r;} spapf_stereo_t;
    typedef struct packed {logic gate_en; logic knee2_en; logic qr_en; logic clip_en;
                           logic pb_en; logic rec_l_en; logic rec_r_en;} spapf_drc_ctl_t;
    localparam spapf_cfg_t CFG_RESET = '{rec: 16'h0000, pb1: 16'h0200, pb2: 16'h0000, gate: 16'h0068,
                                         dynamic_range_controller: 16'h0098, vol_l: VOL_RESET, vol_r: VOL_RESET};
endpackage : spapf_pkg

/* dv/spapf_audio_src.sv */
// Audio interface model: one sample strobe every four clocks while running
module spapf_audio_src (
    input  wire logic                     clk_i,     // Clock
    input  wire logic                     rst_n_i,   // Reset, low
    input  wire logic                     run_i,     // Produce samples
    input  wire spapf_pkg::spapf_stereo_t pb_val_i,  // Next playback sample
    input  wire spapf_pkg::spapf_stereo_t rec_val_i, // Next record sample
    output logic                          fs_o,      // Sample strobe
    output spapf_pkg::spapf_stereo_t      pb_o,      // Playback data
    output spapf_pkg::spapf_stereo_t      rec_o      // Record data
);
    timeunit 1ns;
    timeprecision 1ps;
    import spapf_pkg::*;
    logic [1:0] div;
    logic       hit;
    assign hit = run_i && (div == 2'h3);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div   <= 2'h0;
            fs_o  <= 1'b0;
            pb_o  <= '0;
            rec_o <= '0;
        end else begin
            div   <= div + 2'h1;
            fs_o  <= hit;
            // Data outside a strobe is scrambled, never left at the last value
            pb_o  <= hit ? pb_val_i : ~pb_o;
            rec_o <= hit ? rec_val_i : ~rec_o;
        end
    end
endmodule : spapf_audio_src

/* dv/second_port_audio_path_filters_tb.sv */
// Register and sample path test of the second port filter block
module second_port_audio_path_filters_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spapf_pkg::*;
    logic clk, rst_n, cyc, stb, wr, ack, fs, run, out_valid, sig_det;
    logic [AW-1:0] adr;
    logic [31:0]   wdat, rdat, rd;
    logic [3:0]    wsel;
    spapf_stereo_t pb_in, rec_in, pb_val, rec_val, pb_out, rec_out;
    spapf_drc_ctl_t drc_ctl;
    int num_errors, n_checks, n;
    localparam logic [11:0] IDXS [5] = '{IDX_REC, IDX_PB1, IDX_PB2, IDX_GATE, IDX_DRC};
    localparam logic [15:0] RSTS [5] = '{16'h0000, 16'h0200, 16'h0000, 16'h0068, 16'h0098};
    localparam logic [15:0] MSKS [5] = '{REC_WMASK, PB1_WMASK, PB2_WMASK, GATE_WMASK, DRC_WMASK};

    spapf_filters #(.HOLD_N0(4), .HOLD_N1(8), .HOLD_N2(12), .HOLD_N3(16)) i_dut (
        .CLOCK_I(clk), .RST_N_I(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_SEL_I(wsel), .WB_WE_I(wr), .WB_STB_I(stb), .WB_CYC_I(cyc), .WB_ACK_O(ack),
        .FS_STROBE_I(fs), .PB_I(pb_in), .REC_I(rec_in), .PB_O(pb_out), .REC_O(rec_out),
        .OUT_VALID_O(out_valid), .DRC_CTL_O(drc_ctl), .SIG_DETECT_O(sig_det));
    spapf_audio_src i_src (.clk_i(clk), .rst_n_i(rst_n), .run_i(run), .pb_val_i(pb_val),
        .rec_val_i(rec_val), .fs_o(fs), .pb_o(pb_in), .rec_o(rec_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Classic single cycle; ack and read data taken at the same edge
    task automatic wb(input logic we, input logic [11:0] idx, input logic [15:0] d, input logic [3:0] sel);
        int t;
        t = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; wr <= we; adr <= {idx, 2'b00}; wdat <= {16'h0000, d}; wsel <= sel;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        rd = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        if (ack !== 1'b1) begin
            num_errors++;
            final_report();
        end
    endtask : wb

    task automatic wait_samples(input int cnt);
        int got, t;
        got = 0; t = 0;
        while (got < cnt && t < 20 * cnt) begin
            @(posedge clk);
            #1;
            t++;
            if (out_valid === 1'b1) got++;
        end
        if (got < cnt) begin
            num_errors++;
            final_report();
        end
    endtask : wait_samples

    initial begin
        num_errors = 0; n_checks = 0; rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; wr = 1'b0;
        adr = '0; wdat = '0; wsel = 4'hF; run = 1'b0;
        pb_val = '{l: 24'sd1000, r: 24'sd3000}; rec_val = '{l: 24'sd100000, r: 24'sd100000};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, IDXS[i], 16'h0000, 4'hF);
            check("reset value", rd, {16'h0000, RSTS[i]});
        end
        wb(1'b0, IDX_PB_VOL_L, 16'h0000, 4'hF);
        check("volume reset", rd, 32'h000000C0);
        check("drc outputs", 32'(drc_ctl), 32'h18);
        wb(1'b1, 12'h7FF, 16'hFFFF, 4'hF);
        wb(1'b0, 12'h7FF, 16'h0000, 4'hF);
        check("unmapped", rd, 32'h0);
        run <= 1'b1;
        wait_samples(3);
        check("muted out", 32'(pb_out.l), 32'h0);
        check("rec bypass", 32'(rec_out.l), 32'(rec_val.l));
        check("no detect", 32'(sig_det), 32'h0);
        // Pending volumes only become active together with the update bit; B0h is 6dB down
        wb(1'b1, IDX_PB_VOL_L, 16'h00B0, 4'h1);
        wb(1'b1, IDX_PB_VOL_R, 16'h01B0, 4'h3);
        wb(1'b0, IDX_PB_VOL_L, 16'h0000, 4'hF);
        check("pending vol", rd, 32'h000000B0);
        wb(1'b1, IDX_PB1, 16'h0000, 4'hF);
        wait_samples(3);
        check("left gain", 32'(pb_out.l), 32'(24'sd500));
        check("right gain", 32'(pb_out.r), 32'(24'sd1500));
        wb(1'b1, IDX_PB1, 16'h0080, 4'hF);
        wait_samples(3);
        check("mono left", 32'(pb_out.l), 32'(24'sd1000));
        check("mono right", 32'(pb_out.r), 32'(24'sd1000));
        wb(1'b1, IDX_PB1, 16'h0000, 4'hF);
        pb_val <= '{l: 24'sd100, r: 24'sd100};
        wb(1'b1, IDX_GATE, 16'h0009, 4'hF);
        wait_samples(2);
        check("gate hold", 32'(pb_out.l), 32'(24'sd50));
        wait_samples(8);
        check("gate shut", 32'(pb_out.l), 32'h0);
        wb(1'b0, IDX_STAT, 16'h0000, 4'hF);
        check("gate flag", 32'(rd[1]), 32'h1);
        wb(1'b1, IDX_GATE, 16'h0008, 4'hF);
        wait_samples(2);
        check("gate off", 32'(pb_out.l), 32'(24'sd50));
        wb(1'b1, IDX_REC, 16'h1000, 4'hF);
        wait_samples(4);
        check("hpf right", 32'(rec_out.r), 32'(rec_val.r));
        check("hpf left", 32'(rec_out.l), 32'h0);
        // Fast ramp: one gain step per two samples from B0h
        wb(1'b1, IDX_PB1, 16'h0200, 4'hF);
        wait_samples(1);
        wb(1'b0, IDX_STAT, 16'h0000, 4'hF);
        check("soft ramp", 32'(rd[2]), 32'h0);
        n = 1;
        while (n < 400 && rd[2] !== 1'b1) begin
            wait_samples(1);
            n++;
            wb(1'b0, IDX_STAT, 16'h0000, 4'hF);
        end
        check("ramp length", 32'(n >= 349 && n <= 355), 32'h1);
        // Slow unmute ramp: one step per 32 samples, so a single step after 40
        wb(1'b1, IDX_PB1, 16'h0030, 4'hF);
        wait_samples(40);
        wb(1'b0, IDX_STAT, 16'h0000, 4'hF);
        check("slow unmute", 32'(rd[15:8]), 32'h1);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, IDXS[i], 16'hFFFF, 4'h3);
            wb(1'b0, IDXS[i], 16'h0000, 4'hF);
            check("write mask", rd, {16'h0000, MSKS[i]});
        end
        wait_samples(2);
        check("drc shadow", 32'(drc_ctl), 32'h7F);
        // Record left near -38dB against a -42dB level threshold
        wb(1'b1, IDX_DRC, 16'h40C2, 4'hF);
        wait_samples(120);
        check("rms detect", 32'(sig_det), 32'h1);
        final_report();
    end
endmodule : second_port_audio_path_filters_tb
